// ---- pkg/iord_pkg.sv ----
// Purpose: Shared constants and types for the I/O register space decoder
// Assumes: 8-bit data, 64 direct I/O locations, one core clock
// Notes: Reserved locations have all masks zero
package iord_pkg;

    // Address ranges seen by the core
    localparam logic [7:0] BIT_IO_TOP = 8'h1F;
    localparam logic [7:0] IO_TOP = 8'h3F;
    localparam logic [7:0] DATA_IO_OFS = 8'h20;
    localparam logic [7:0] EXT_LO = 8'h60;
    localparam int IO_CNT = 64;
    localparam logic [7:0] RST_VAL = 8'h00;
    localparam int NVM_TOP_ADDR_BIT = 8;

    // Register offsets (I/O addresses)
    localparam logic [5:0] A_PORT_A_INPUT_LEVELS = 6'h00;
    localparam logic [5:0] A_PORT_A_DIRECTION = 6'h01;
    localparam logic [5:0] A_PORT_A_OUTPUT = 6'h02;
    localparam logic [5:0] A_PORT_B_INPUT_LEVELS = 6'h03;
    localparam logic [5:0] A_PORT_B_DIRECTION = 6'h04;
    localparam logic [5:0] A_PORT_B_OUTPUT = 6'h05;
    localparam logic [5:0] A_PORT_PULLUP_DRIVE_CONTROL = 6'h12;
    localparam logic [5:0] A_TFLG0 = 6'h15;
    localparam logic [5:0] A_TFLG1 = 6'h16;
    localparam logic [5:0] A_PCFLG = 6'h1B;
    localparam logic [5:0] A_EXFLG = 6'h1C;
    localparam logic [5:0] A_EXMSK = 6'h1D;
    localparam logic [5:0] A_SCR0 = 6'h1E;
    localparam logic [5:0] A_NVMC = 6'h1F;
    localparam logic [5:0] A_NVMD = 6'h20;
    localparam logic [5:0] A_NVMAL = 6'h21;
    localparam logic [5:0] A_NVMAH = 6'h22;
    localparam logic [5:0] A_TGCTL = 6'h23;
    localparam logic [5:0] A_T0CA = 6'h25;
    localparam logic [5:0] A_T0CB = 6'h26;
    localparam logic [5:0] A_T0CNT = 6'h27;
    localparam logic [5:0] A_T0CMP = 6'h28;
    localparam logic [5:0] A_SCR1 = 6'h2A;
    localparam logic [5:0] A_SCR2 = 6'h2B;
    localparam logic [5:0] A_SPCTL = 6'h2C;
    localparam logic [5:0] A_SPSTA = 6'h2D;
    localparam logic [5:0] A_SPDAT = 6'h2E;
    localparam logic [5:0] A_CMPCS = 6'h30;
    localparam logic [5:0] A_DBGD = 6'h31;
    localparam logic [5:0] A_SLPC = 6'h33;

    // Field layouts: writable, write-one-to-clear and live status bits
    localparam logic [7:0] M_ALL = 8'hFF;
    localparam logic [7:0] M_PORT_PULLUP_DRIVE_CONTROL = 8'h33;
    localparam logic [7:0] M_TFLG0 = 8'h03;
    localparam logic [7:0] M_TFLG1 = 8'h27;
    localparam logic [7:0] M_TWO = 8'h03;
    localparam logic [7:0] M_NVMC = 8'h3F;
    localparam logic [7:0] M_NVMAH = 8'h01;
    localparam logic [7:0] M_TGCTL = 8'h83;
    localparam logic [7:0] M_T0CA = 8'hC3;
    localparam logic [7:0] M_T0CB = 8'h87;
    localparam logic [7:0] M_SPSTA_W = 8'h01;
    localparam logic [7:0] M_SPSTA_S = 8'hC0;
    localparam logic [7:0] M_CMPCS_W = 8'hCF;
    localparam logic [7:0] M_CMPCS_C = 8'h10;
    localparam logic [7:0] M_CMPCS_S = 8'h20;
    localparam logic [7:0] M_SLPC = 8'h07;
    localparam int POS_CMP_OUT = 5;
    localparam int POS_SP_DONE = 7;
    localparam int POS_SP_COLL = 6;

    typedef enum logic [2:0] {
        OP_IO_READ = 3'h0,
        OP_IO_WRITE = 3'h1,
        OP_SET_IO_BIT = 3'h2,
        OP_CLEAR_IO_BIT = 3'h3,
        OP_SKIP_IF_IO_BIT_SET = 3'h4,
        OP_SKIP_IF_IO_BIT_CLEAR = 3'h5,
        OP_DATA_LOAD = 3'h6,
        OP_DATA_STORE = 3'h7
    } iord_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXT = 2'b10
    } iord_st_t;

    typedef struct packed {
        logic valid;
        iord_op_t op;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } iord_req_t;

    typedef struct packed {
        logic done;
        logic skip;
        logic fault;
        logic [7:0] rdata;
    } iord_rsp_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } iord_ext_t;

    typedef struct packed {
        logic [7:0] tflg0;
        logic [7:0] tflg1;
        logic [7:0] pcflg;
        logic [7:0] exflg;
        logic cmp_irq;
    } iord_evt_t;

    typedef struct packed {
        logic sp_done;
        logic sp_coll;
        logic cmp_out;
    } iord_stat_t;

    typedef struct packed {
        logic [7:0] port_a_out;
        logic [7:0] port_a_dir;
        logic [7:0] port_b_out;
        logic [7:0] port_b_dir;
        logic [7:0] pullup_ctl;
        logic [7:0] tflg0;
        logic [7:0] tflg1;
        logic [7:0] pcflg;
        logic [7:0] exflg;
        logic [7:0] exmsk;
        logic [7:0] nvm_ctl;
        logic [7:0] nvm_data;
        logic [NVM_TOP_ADDR_BIT:0] nvm_addr;
        logic [7:0] tgctl;
        logic [7:0] t0ca;
        logic [7:0] t0cb;
        logic [7:0] t0cnt;
        logic [7:0] t0cmp;
        logic [7:0] sp_ctl;
        logic [7:0] sp_data;
        logic [7:0] cmp_cs;
        logic [7:0] dbg_data;
        logic [7:0] sleep_ctl;
    } iord_periph_t;

    typedef struct packed {
        iord_st_t st;
        logic [IO_CNT-1:0][7:0] io;
        logic [7:0] pa1;
        logic [7:0] pa2;
        logic [7:0] pa3;
        logic [7:0] pb1;
        logic [7:0] pb2;
        logic [7:0] pb3;
        iord_rsp_t rsp;
        iord_ext_t ext;
    } iord_state_t;

endpackage : iord_pkg

// ---- rtl/iord_decoder.sv ----
// Purpose: Low I/O register space decoder and register file
// Assumes: Core holds a request until DONE; events are clock-synchronous
// Notes: Peripheral engines sit outside; they see control bytes only
`timescale 1ns/1ps

// Summary of operation
// - Bit set/clear only for addresses 0x00-0x1F
// - Skip-if-bit tests for bit-accessible registers
// - Bit operations touch only the addressed bit
// - Status flags clear on writing one
// - I/O read/write cover addresses 0x00-0x3F
// - Data address equals I/O address plus 0x20
// - Extended region 0x60-0xFF only by load/store
// - NVM address bits above top bit ignored
module iord_decoder (
    input wire logic SYS_CLK,
    input wire logic RST,
    input iord_pkg::iord_req_t REQ,
    input wire logic [7:0] PIN_A,
    input wire logic [7:0] PIN_B,
    input iord_pkg::iord_evt_t EVT,
    input iord_pkg::iord_stat_t STAT,
    input wire logic [7:0] EXT_RDATA,
    output iord_pkg::iord_rsp_t RSP,
    output iord_pkg::iord_ext_t EXT,
    output iord_pkg::iord_periph_t PERIPH
);

    iord_pkg::iord_state_t s_ff;
    iord_pkg::iord_state_t nxt_s;

    // Bits that software may write plainly
    function automatic logic [7:0] wr_mask(input logic [5:0] ix);
        case (ix)
            iord_pkg::A_PORT_A_DIRECTION, iord_pkg::A_PORT_A_OUTPUT,
            iord_pkg::A_PORT_B_DIRECTION, iord_pkg::A_PORT_B_OUTPUT,
            iord_pkg::A_SCR0, iord_pkg::A_NVMD, iord_pkg::A_NVMAL,
            iord_pkg::A_T0CNT, iord_pkg::A_T0CMP,
            iord_pkg::A_SCR1, iord_pkg::A_SCR2,
            iord_pkg::A_SPCTL, iord_pkg::A_SPDAT,
            iord_pkg::A_DBGD: wr_mask = iord_pkg::M_ALL;
            iord_pkg::A_PORT_PULLUP_DRIVE_CONTROL: wr_mask = iord_pkg::M_PORT_PULLUP_DRIVE_CONTROL;
            iord_pkg::A_EXMSK: wr_mask = iord_pkg::M_TWO;
            iord_pkg::A_NVMC: wr_mask = iord_pkg::M_NVMC;
            iord_pkg::A_NVMAH: wr_mask = iord_pkg::M_NVMAH;
            iord_pkg::A_TGCTL: wr_mask = iord_pkg::M_TGCTL;
            iord_pkg::A_T0CA: wr_mask = iord_pkg::M_T0CA;
            iord_pkg::A_T0CB: wr_mask = iord_pkg::M_T0CB;
            iord_pkg::A_SPSTA: wr_mask = iord_pkg::M_SPSTA_W;
            iord_pkg::A_CMPCS: wr_mask = iord_pkg::M_CMPCS_W;
            iord_pkg::A_SLPC: wr_mask = iord_pkg::M_SLPC;
            default: wr_mask = 8'h00;
        endcase
    endfunction : wr_mask

    // Flags that clear when written with one
    function automatic logic [7:0] w1c_mask(input logic [5:0] ix);
        case (ix)
            iord_pkg::A_TFLG0: w1c_mask = iord_pkg::M_TFLG0;
            iord_pkg::A_TFLG1: w1c_mask = iord_pkg::M_TFLG1;
            iord_pkg::A_PCFLG: w1c_mask = iord_pkg::M_TWO;
            iord_pkg::A_EXFLG: w1c_mask = iord_pkg::M_TWO;
            iord_pkg::A_CMPCS: w1c_mask = iord_pkg::M_CMPCS_C;
            default: w1c_mask = 8'h00;
        endcase
    endfunction : w1c_mask

    // Readable bits; everything else reads zero
    function automatic logic [7:0] rd_mask(input logic [5:0] ix);
        case (ix)
            iord_pkg::A_PORT_A_INPUT_LEVELS, iord_pkg::A_PORT_B_INPUT_LEVELS: rd_mask = iord_pkg::M_ALL;
            iord_pkg::A_SPSTA:
                rd_mask = iord_pkg::M_SPSTA_W | iord_pkg::M_SPSTA_S;
            iord_pkg::A_CMPCS:
                rd_mask = iord_pkg::M_CMPCS_W | iord_pkg::M_CMPCS_C |
                    iord_pkg::M_CMPCS_S;
            default: rd_mask = wr_mask(ix) | w1c_mask(ix);
        endcase
    endfunction : rd_mask

    // One byte update under a lane mask; bit ops pass a single-bit mask
    function automatic logic [7:0] wr_byte(
        input logic [7:0] old,
        input logic [7:0] wd,
        input logic [7:0] bm,
        input logic [5:0] ix
    );
        logic [7:0] wm;
        logic [7:0] c1;
        wm = wr_mask(ix) & bm;
        c1 = w1c_mask(ix) & bm & wd;
        wr_byte = ((old & ~wm) | (wd & wm)) & ~c1;
    endfunction : wr_byte

    always_comb begin
        logic [5:0] ix;
        logic hit;
        logic is_rd;
        logic is_wr;
        logic [7:0] bm;
        logic [7:0] wd;
        logic [7:0] rv;
        ix = 6'h00;
        hit = 1'b0;
        is_rd = 1'b0;
        is_wr = 1'b0;
        bm = iord_pkg::M_ALL;
        wd = REQ.wdata;
        rv = 8'h00;
        nxt_s = s_ff;
        nxt_s.rsp.done = 1'b0;
        nxt_s.rsp.skip = 1'b0;
        nxt_s.rsp.fault = 1'b0;
        nxt_s.ext.req = 1'b0;

        // Pins pass three stages; a level counts once stages two and three agree
        nxt_s.pa1 = PIN_A;
        nxt_s.pa2 = s_ff.pa1;
        nxt_s.pa3 = s_ff.pa2;
        nxt_s.pb1 = PIN_B;
        nxt_s.pb2 = s_ff.pb1;
        nxt_s.pb3 = s_ff.pb2;
        if (s_ff.pa2 == s_ff.pa3) begin
            nxt_s.io[iord_pkg::A_PORT_A_INPUT_LEVELS] = s_ff.pa3;
        end
        if (s_ff.pb2 == s_ff.pb3) begin
            nxt_s.io[iord_pkg::A_PORT_B_INPUT_LEVELS] = s_ff.pb3;
        end

        // Live status bits are mirrored, never written by software
        nxt_s.io[iord_pkg::A_SPSTA][iord_pkg::POS_SP_DONE] = STAT.sp_done;
        nxt_s.io[iord_pkg::A_SPSTA][iord_pkg::POS_SP_COLL] = STAT.sp_coll;
        nxt_s.io[iord_pkg::A_CMPCS][iord_pkg::POS_CMP_OUT] = STAT.cmp_out;

        case (s_ff.st)
            iord_pkg::ST_IDLE: begin
                if (REQ.valid) begin
                    case (REQ.op)
                        iord_pkg::OP_IO_READ, iord_pkg::OP_IO_WRITE: begin
                            hit = (REQ.addr <= iord_pkg::IO_TOP);
                            ix = REQ.addr[5:0];
                            is_rd = (REQ.op == iord_pkg::OP_IO_READ);
                            is_wr = !is_rd;
                        end
                        iord_pkg::OP_SET_IO_BIT,
                        iord_pkg::OP_CLEAR_IO_BIT: begin
                            hit = (REQ.addr <= iord_pkg::BIT_IO_TOP);
                            ix = REQ.addr[5:0];
                            is_wr = 1'b1;
                            bm = 8'(8'h01 << REQ.bit_sel);
                            wd = (REQ.op == iord_pkg::OP_SET_IO_BIT) ?
                                bm : 8'h00;
                        end
                        iord_pkg::OP_SKIP_IF_IO_BIT_SET,
                        iord_pkg::OP_SKIP_IF_IO_BIT_CLEAR: begin
                            hit = (REQ.addr <= iord_pkg::BIT_IO_TOP);
                            ix = REQ.addr[5:0];
                            is_rd = 1'b1;
                        end
                        default: begin
                            // Data load or store
                            is_rd = (REQ.op == iord_pkg::OP_DATA_LOAD);
                            is_wr = !is_rd;
                            ix = 6'(REQ.addr - iord_pkg::DATA_IO_OFS);
                            hit = (REQ.addr >= iord_pkg::DATA_IO_OFS) &&
                                (REQ.addr < iord_pkg::EXT_LO);
                            if (REQ.addr >= iord_pkg::EXT_LO) begin
                                // Extended space only by data access
                                nxt_s.ext.req = 1'b1;
                                nxt_s.ext.we = is_wr;
                                nxt_s.ext.addr = REQ.addr;
                                nxt_s.ext.wdata = REQ.wdata;
                                nxt_s.st = iord_pkg::ST_EXT;
                                is_rd = 1'b0;
                                is_wr = 1'b0;
                            end
                        end
                    endcase

                    if (hit) begin
                        rv = s_ff.io[ix] & rd_mask(ix);
                        if (is_wr) begin
                            nxt_s.io[ix] = wr_byte(s_ff.io[ix], wd, bm, ix);
                        end
                    end
                    if (nxt_s.st == iord_pkg::ST_IDLE) begin
                        // Out-of-range requests answer with a fault, no effect
                        nxt_s.rsp.done = 1'b1;
                        nxt_s.rsp.fault = !hit;
                        nxt_s.rsp.rdata = is_rd ? rv : 8'h00;
                        if (hit && (REQ.op ==
                            iord_pkg::OP_SKIP_IF_IO_BIT_SET)) begin
                            nxt_s.rsp.skip = rv[REQ.bit_sel];
                        end
                        if (hit && (REQ.op ==
                            iord_pkg::OP_SKIP_IF_IO_BIT_CLEAR)) begin
                            nxt_s.rsp.skip = !rv[REQ.bit_sel];
                        end
                    end
                end
            end
            iord_pkg::ST_EXT: begin
                // External answer is sampled one cycle after the strobe
                nxt_s.rsp.done = 1'b1;
                nxt_s.rsp.rdata = s_ff.ext.we ? 8'h00 : EXT_RDATA;
                nxt_s.st = iord_pkg::ST_IDLE;
            end
            default: begin
                nxt_s.st = iord_pkg::ST_IDLE;
            end
        endcase

        // Hardware set wins over a clear in the same cycle
        nxt_s.io[iord_pkg::A_TFLG0] = nxt_s.io[iord_pkg::A_TFLG0] |
            (EVT.tflg0 & iord_pkg::M_TFLG0);
        nxt_s.io[iord_pkg::A_TFLG1] = nxt_s.io[iord_pkg::A_TFLG1] |
            (EVT.tflg1 & iord_pkg::M_TFLG1);
        nxt_s.io[iord_pkg::A_PCFLG] = nxt_s.io[iord_pkg::A_PCFLG] |
            (EVT.pcflg & iord_pkg::M_TWO);
        nxt_s.io[iord_pkg::A_EXFLG] = nxt_s.io[iord_pkg::A_EXFLG] |
            (EVT.exflg & iord_pkg::M_TWO);
        nxt_s.io[iord_pkg::A_CMPCS] = nxt_s.io[iord_pkg::A_CMPCS] |
            (EVT.cmp_irq ? iord_pkg::M_CMPCS_C : 8'h00);
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            nxt_s_reset: begin
                s_ff <= '0;
                s_ff.st <= iord_pkg::ST_IDLE;
                for (int i = 0; i < iord_pkg::IO_CNT; i++) begin
                    s_ff.io[i] <= iord_pkg::RST_VAL;
                end
            end
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign RSP = s_ff.rsp;
    assign EXT = s_ff.ext;

    // Control bytes for the peripheral engines, straight from storage
    assign PERIPH.port_a_out = s_ff.io[iord_pkg::A_PORT_A_OUTPUT];
    assign PERIPH.port_a_dir = s_ff.io[iord_pkg::A_PORT_A_DIRECTION];
    assign PERIPH.port_b_out = s_ff.io[iord_pkg::A_PORT_B_OUTPUT];
    assign PERIPH.port_b_dir = s_ff.io[iord_pkg::A_PORT_B_DIRECTION];
    assign PERIPH.pullup_ctl = s_ff.io[iord_pkg::A_PORT_PULLUP_DRIVE_CONTROL];
    assign PERIPH.tflg0 = s_ff.io[iord_pkg::A_TFLG0];
    assign PERIPH.tflg1 = s_ff.io[iord_pkg::A_TFLG1];
    assign PERIPH.pcflg = s_ff.io[iord_pkg::A_PCFLG];
    assign PERIPH.exflg = s_ff.io[iord_pkg::A_EXFLG];
    assign PERIPH.exmsk = s_ff.io[iord_pkg::A_EXMSK];
    assign PERIPH.nvm_ctl = s_ff.io[iord_pkg::A_NVMC];
    assign PERIPH.nvm_data = s_ff.io[iord_pkg::A_NVMD];
    // Only bits up to the top address bit exist; higher ones never stored
    assign PERIPH.nvm_addr = {s_ff.io[iord_pkg::A_NVMAH][0],
        s_ff.io[iord_pkg::A_NVMAL]};
    assign PERIPH.tgctl = s_ff.io[iord_pkg::A_TGCTL];
    assign PERIPH.t0ca = s_ff.io[iord_pkg::A_T0CA];
    assign PERIPH.t0cb = s_ff.io[iord_pkg::A_T0CB];
    assign PERIPH.t0cnt = s_ff.io[iord_pkg::A_T0CNT];
    assign PERIPH.t0cmp = s_ff.io[iord_pkg::A_T0CMP];
    assign PERIPH.sp_ctl = s_ff.io[iord_pkg::A_SPCTL];
    assign PERIPH.sp_data = s_ff.io[iord_pkg::A_SPDAT];
    assign PERIPH.cmp_cs = s_ff.io[iord_pkg::A_CMPCS];
    assign PERIPH.dbg_data = s_ff.io[iord_pkg::A_DBGD];
    assign PERIPH.sleep_ctl = s_ff.io[iord_pkg::A_SLPC];

endmodule : iord_decoder

// ---- sim/iord_core_model.sv ----
// Purpose: Core-side model issuing one register request at a time
// Assumes: Decoder answers with a done pulse within a few cycles
// Notes: Drops the request in the done cycle so it is not taken twice
`timescale 1ns/1ps
module iord_core_model (
    input wire logic SYS_CLK,
    input iord_pkg::iord_rsp_t RSP,
    output iord_pkg::iord_req_t REQ
);
    initial begin
        REQ = '0;
    end

    task automatic xfer(input iord_pkg::iord_op_t op, input logic [7:0] a,
        input logic [2:0] b, input logic [7:0] d,
        output iord_pkg::iord_rsp_t r);
        int n;
        @(negedge SYS_CLK);
        REQ = '{valid: 1'b1, op: op, addr: a, bit_sel: b, wdata: d};
        r = '0;
        for (n = 0; n < 6 && r.done !== 1'b1; n++) begin
            @(negedge SYS_CLK);
            if (RSP.done === 1'b1) r = RSP;
        end
        // Released address and data lines flip so stale values never look valid
        REQ.valid = 1'b0;
        REQ.addr = ~a;
        REQ.wdata = ~d;
    endtask : xfer
endmodule : iord_core_model

// ---- sim/iord_decoder_props.sv ----
// Purpose: Port-level checks of the I/O register space decoder
// Assumes: Core holds a request until done and drops it in that cycle
// Notes: A request counts as taken unless the extended wait is running
`timescale 1ns/1ps
module iord_decoder_props (
    input wire logic SYS_CLK,
    input wire logic RST,
    input iord_pkg::iord_req_t REQ,
    input wire logic [7:0] PIN_A,
    input wire logic [7:0] PIN_B,
    input iord_pkg::iord_evt_t EVT,
    input iord_pkg::iord_stat_t STAT,
    input wire logic [7:0] EXT_RDATA,
    input iord_pkg::iord_rsp_t RSP,
    input iord_pkg::iord_ext_t EXT,
    input iord_pkg::iord_periph_t PERIPH
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    // Op classes by encoding: 0 io, 1 bit, 2 skip, 3 data
    wire logic take = REQ.valid && !EXT.req;
    wire logic [1:0] cls = REQ.op[2:1];
    wire logic [7:0] ad = REQ.addr;
    wire logic [7:0] hot = 8'h01 << REQ.bit_sel;
    wire logic [7:0] dir = PERIPH.port_a_dir;

    sequence s_fault;
        RSP.done && RSP.fault && RSP.rdata == 8'h00;
    endsequence
    sequence s_ok;
        RSP.done && !RSP.fault;
    endsequence
    sequence s_ext_issue;
        EXT.req && EXT.addr == $past(ad) && EXT.we == $past(REQ.op[0]);
    endsequence

    property p_bit_range;
        take && cls inside {2'b01, 2'b10} && ad > 8'h1F |=> s_fault;
    endproperty
    a_bit_range: assert property (p_bit_range)
        else $error("bit op above low range not refused");
    property p_skip;
        take && cls == 2'b10 && ad == 8'h01 |=> RSP.done &&
            RSP.skip == ($past(dir[REQ.bit_sel]) ^ $past(REQ.op[0]));
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip result wrong");
    property p_bit_only;
        take && cls == 2'b01 && ad == 8'h01 |=> dir == ($past(REQ.op[0])
            ? $past(dir & ~hot) : $past(dir | hot));
    endproperty
    a_bit_only: assert property (p_bit_only)
        else $error("bit op changed other bits");
    property p_w1c;
        take && cls == 2'b00 && REQ.op[0] && ad == 8'h1C && EVT.exflg == 8'h00
            |=> PERIPH.exflg == $past(PERIPH.exflg & ~REQ.wdata);
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("flag write-one clear wrong");
    property p_io_ok;
        take && cls == 2'b00 && ad <= 8'h3F |=> s_ok;
    endproperty
    a_io_ok: assert property (p_io_ok)
        else $error("io access in range not done");
    property p_io_range;
        take && cls == 2'b00 && ad > 8'h3F |=> s_fault;
    endproperty
    a_io_range: assert property (p_io_range)
        else $error("io access above range not refused");
    property p_alias;
        take && cls == 2'b11 && REQ.op[0] && ad == 8'h21
            |=> s_ok ##0 dir == $past(REQ.wdata);
    endproperty
    a_alias: assert property (p_alias)
        else $error("data alias store missed");
    property p_ext;
        take && cls == 2'b11 && ad >= 8'h60 |=> s_ext_issue ##1 s_ok;
    endproperty
    a_ext: assert property (p_ext)
        else $error("extended access not issued");
    property p_nvm;
        take && cls == 2'b00 && REQ.op[0] && ad == 8'h22 |=> PERIPH.nvm_addr
            == {$past(REQ.wdata[0]), $past(PERIPH.nvm_addr[7:0])};
    endproperty
    a_nvm: assert property (p_nvm)
        else $error("nvm address top bits not ignored");
    property p_resv;
        take && REQ.op == iord_pkg::OP_IO_READ && ad inside {[8'h06:8'h11]}
            |=> s_ok ##0 RSP.rdata == 8'h00;
    endproperty
    a_resv: assert property (p_resv)
        else $error("reserved address read not zero");
endmodule : iord_decoder_props

bind iord_decoder iord_decoder_props iord_decoder_props_i (
    .SYS_CLK(SYS_CLK),
    .RST(RST),
    .REQ(REQ),
    .PIN_A(PIN_A),
    .PIN_B(PIN_B),
    .EVT(EVT),
    .STAT(STAT),
    .EXT_RDATA(EXT_RDATA),
    .RSP(RSP),
    .EXT(EXT),
    .PERIPH(PERIPH)
);

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the I/O register space decoder
// Assumes: Core model issues one request at a time
// Notes: Extended space answers with the inverted address
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
end
module tb;
    typedef struct packed {
        iord_pkg::iord_op_t op;
        logic [7:0] a;
        logic [2:0] b;
        logic [7:0] d;
        logic [7:0] rd;
        logic ft;
    } iord_row_t;
    localparam iord_pkg::iord_op_t k_rd = iord_pkg::OP_IO_READ;
    localparam iord_pkg::iord_op_t k_wr = iord_pkg::OP_IO_WRITE;
    localparam iord_pkg::iord_op_t k_set = iord_pkg::OP_SET_IO_BIT;
    localparam iord_pkg::iord_op_t k_clr = iord_pkg::OP_CLEAR_IO_BIT;
    localparam iord_pkg::iord_op_t k_sks = iord_pkg::OP_SKIP_IF_IO_BIT_SET;
    localparam iord_pkg::iord_op_t k_skc = iord_pkg::OP_SKIP_IF_IO_BIT_CLEAR;
    localparam iord_pkg::iord_op_t k_ld = iord_pkg::OP_DATA_LOAD;
    localparam iord_pkg::iord_op_t k_st = iord_pkg::OP_DATA_STORE;
    // Skip rows keep the expected skip in bit 0 of rd
    localparam iord_row_t rows [27] = '{
        '{k_wr, 8'h1E, 3'h0, 8'h5A, 8'h00, '0},
        '{k_rd, 8'h1E, 3'h0, 8'h00, 8'h5A, '0},
        '{k_ld, 8'h3E, 3'h0, 8'h00, 8'h5A, '0},
        '{k_rd, 8'h00, 3'h0, 8'h00, 8'hA5, '0},
        '{k_ld, 8'h23, 3'h0, 8'h00, 8'h3C, '0},
        '{k_rd, 8'h2D, 3'h0, 8'h00, 8'h80, '0},
        '{k_rd, 8'h30, 3'h0, 8'h00, 8'h20, '0},
        '{k_rd, 8'h40, 3'h0, 8'h00, 8'h00, '1},
        '{k_ld, 8'h1E, 3'h0, 8'h00, 8'h00, '1},
        '{k_wr, 8'h60, 3'h0, 8'hFF, 8'h00, '1},
        '{k_st, 8'h21, 3'h0, 8'h44, 8'h00, '0},
        '{k_set, 8'h01, 3'h3, 8'h00, 8'h00, '0},
        '{k_rd, 8'h01, 3'h0, 8'h00, 8'h4C, '0},
        '{k_sks, 8'h01, 3'h3, 8'h00, 8'h01, '0},
        '{k_skc, 8'h01, 3'h6, 8'h00, 8'h00, '0},
        '{k_clr, 8'h01, 3'h2, 8'h00, 8'h00, '0},
        '{k_rd, 8'h01, 3'h0, 8'h00, 8'h48, '0},
        '{k_set, 8'h1F, 3'h0, 8'h00, 8'h00, '0},
        '{k_rd, 8'h1F, 3'h0, 8'h00, 8'h01, '0},
        '{k_set, 8'h20, 3'h0, 8'h00, 8'h00, '1},
        '{k_skc, 8'h21, 3'h0, 8'h00, 8'h00, '1},
        '{k_wr, 8'h12, 3'h0, 8'h33, 8'h00, '0},
        '{k_rd, 8'h12, 3'h0, 8'h00, 8'h33, '0},
        '{k_wr, 8'h22, 3'h0, 8'h01, 8'h00, '0},
        '{k_rd, 8'h22, 3'h0, 8'h00, 8'h01, '0},
        '{k_rd, 8'h3F, 3'h0, 8'h00, 8'h00, '0},
        '{k_rd, 8'h08, 3'h0, 8'h00, 8'h00, '0}
    };
    logic sys_clk;
    logic rst;
    logic [7:0] pin_a;
    logic [7:0] pin_b;
    iord_pkg::iord_evt_t evt;
    iord_pkg::iord_stat_t stat;
    iord_pkg::iord_req_t req;
    iord_pkg::iord_rsp_t rsp;
    iord_pkg::iord_ext_t ext;
    iord_pkg::iord_periph_t periph;
    iord_pkg::iord_rsp_t r;
    wire logic [7:0] ext_rdata = ~ext.addr;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    iord_decoder iord_decoder_i (
        .SYS_CLK(sys_clk),
        .RST(rst),
        .REQ(req),
        .PIN_A(pin_a),
        .PIN_B(pin_b),
        .EVT(evt),
        .STAT(stat),
        .EXT_RDATA(ext_rdata),
        .RSP(rsp),
        .EXT(ext),
        .PERIPH(periph)
    );
    iord_core_model iord_core_model_i (
        .SYS_CLK(sys_clk),
        .RSP(rsp),
        .REQ(req)
    );

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic go(input iord_pkg::iord_op_t op, input logic [7:0] a,
        input logic [2:0] b, input logic [7:0] d);
        iord_core_model_i.xfer(op, a, b, d, r);
    endtask : go
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        go(k_rd, a, 3'h0, 8'h00);
        `CHK("read data", e, r.rdata)
    endtask : rd_chk
    task automatic pulse(input logic [7:0] f);
        @(negedge sys_clk);
        evt = {f, f, f, f, f[0]};
        @(negedge sys_clk);
        evt = '0;
    endtask : pulse

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Hang guard, far above the hundred or so cycles needed
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        rst = 1'b1;
        pin_a = 8'hA5;
        pin_b = 8'h3C;
        evt = '0;
        stat = '{sp_done: 1'b1, sp_coll: 1'b0, cmp_out: 1'b1};
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        `CHK("periph reset", '0, periph)
        $display("reset test done");
        // Reserved addresses are only ever read
        foreach (rows[i]) begin
            go(rows[i].op, rows[i].a, rows[i].b, rows[i].d);
            `CHK("done", 1'b1, r.done)
            `CHK("fault", rows[i].ft, r.fault)
            if (rows[i].op inside {k_rd, k_ld} || rows[i].ft)
                `CHK("rdata", rows[i].rd, r.rdata)
            if (rows[i].op inside {k_sks, k_skc} && !rows[i].ft)
                `CHK("skip", rows[i].rd[0], r.skip)
        end
        `CHK("nvm addr", 9'h100, periph.nvm_addr)
        $display("table test done");
        go(k_st, 8'h90, 3'h0, 8'h77);
        `CHK("ext store", 8'h77, ext.wdata)
        go(k_ld, 8'h90, 3'h0, 8'h00);
        `CHK("ext load", 8'h6F, r.rdata)
        go(k_ld, 8'hFF, 3'h0, 8'h00);
        `CHK("ext top", 8'h00, r.rdata)
        $display("extended test done");
        pulse(8'h03);
        rd_chk(8'h15, 8'h03);
        rd_chk(8'h1C, 8'h03);
        go(k_wr, 8'h1C, 3'h0, 8'h01);
        rd_chk(8'h1C, 8'h02);
        go(k_clr, 8'h1C, 3'h1, 8'h00);
        rd_chk(8'h1C, 8'h02);
        pulse(8'h03);
        go(k_set, 8'h1C, 3'h1, 8'h00);
        rd_chk(8'h1C, 8'h01);
        // Clear and hardware set in one cycle: the set must win
        fork
            go(k_wr, 8'h1C, 3'h0, 8'h01);
            pulse(8'h01);
        join
        rd_chk(8'h1C, 8'h01);
        $display("flag test done");
        @(negedge sys_clk);
        rst = 1'b1;
        @(negedge sys_clk);
        `CHK("periph mid reset", '0, periph)
        `CHK("rsp mid reset", '0, rsp)
        rst = 1'b0;
        rd_chk(8'h1E, 8'h00);
        go(k_wr, 8'h1D, 3'h0, 8'h03);
        rd_chk(8'h1D, 8'h03);
        $display("second reset test done");
        wrap_up();
    end
endmodule : tb
